// ===== rtl/dsp_host.sv
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_host #(
   parameter int ADDR_W = `DSP_ADDR_W,
   parameter int DATA_W = `DSP_DATA_W,
   parameter int FIFO_DEPTH = `DSP_FIFO_DEPTH,
   parameter int K_HALF = `DSP_K_HALF_CYC
) (
   // Memory link
   dsp_link_if.host LINK,
   // Request stream
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire dsp_pkg::dsp_dir_t REQ_RW,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA0,
   input wire logic [DATA_W-1:0] REQ_WDATA1,
   input wire logic [DATA_W/`DSP_LANE_W-1:0] REQ_MASK0_N,
   input wire logic [DATA_W/`DSP_LANE_W-1:0] REQ_MASK1_N,
   // Mode
   input wire logic SINGLE_CLK,
   // Read return
   output logic RD_VALID,
   output logic [DATA_W-1:0] RD_DATA0,
   output logic [DATA_W-1:0] RD_DATA1,
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N
);
   import dsp_pkg::*;

   localparam int LANES = DATA_W / `DSP_LANE_W;
   localparam int REQ_W = 1 + ADDR_W + 2 * DATA_W + 2 * LANES;
   localparam int PH_W = $clog2(2 * K_HALF);

   logic head_valid;
   logic head_ready;
   logic [REQ_W-1:0] head;
   logic h_rw_raw;
   dsp_dir_t h_rw;
   logic [ADDR_W-1:0] h_addr;
   logic [DATA_W-1:0] h_d0;
   logic [DATA_W-1:0] h_d1;
   logic [LANES-1:0] h_m0;
   logic [LANES-1:0] h_m1;

   logic [PH_W-1:0] ph_q;
   logic [PH_W-1:0] ph_next;
   logic k_next;
   logic at_rise;
   logic mid_hi;
   logic mid_lo;
   logic issue;
   logic k_q;
   logic k_n_q;
   logic c_q;
   logic c_n_q;
   logic single_q;
   logic define_n_q;
   logic rw_q;
   logic [ADDR_W-1:0] addr_q;
   logic cmd_rd_q;
   logic last_rd_q;
   logic wr_stage_q;
   logic wr_word1_q;
   logic [DATA_W-1:0] wd0_q;
   logic [DATA_W-1:0] wd1_q;
   logic [LANES-1:0] m0_q;
   logic [LANES-1:0] m1_q;
   logic [DATA_W-1:0] wd1_drv_q;
   logic [LANES-1:0] m1_drv_q;
   logic [DATA_W-1:0] dq_o_q;
   logic dq_oe_n_q;
   logic [LANES-1:0] mask_n_q;

   logic [DATA_W+1:0] ret_s1_q;
   logic [DATA_W+1:0] ret_s2_q;
   logic [1:0] echo_prev_q;
   logic echo_rise;
   logic echon_rise;
   logic [1:0] hist_q;
   logic cap_q;
   logic rd_valid_q;
   logic [DATA_W-1:0] rd_d0_q;
   logic [DATA_W-1:0] rd_d1_q;

   // Requests wait here; the link drains one per K period
   dsp_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_req_fifo (
      .IN_VALID(REQ_VALID),
      .IN_READY(REQ_READY),
      .IN_DATA({REQ_RW, REQ_ADDR, REQ_WDATA0, REQ_WDATA1, REQ_MASK0_N, REQ_MASK1_N}),
      .OUT_VALID(head_valid),
      .OUT_READY(head_ready),
      .OUT_DATA(head),
      .CLOCK(CLOCK),
      .RST_N(RST_N)
   );

   assign {h_rw_raw, h_addr, h_d0, h_d1, h_m0, h_m1} = head;
   assign h_rw = dsp_dir_t'(h_rw_raw);

   // K divider, phase 0 is the rising edge
   assign ph_next = (ph_q == PH_W'(2 * K_HALF - 1)) ? '0 : ph_q + 1'b1;
   assign k_next = (ph_next < PH_W'(K_HALF));
   assign at_rise = (ph_q == '0);
   assign mid_hi = (ph_q == PH_W'(K_HALF / 2));
   assign mid_lo = (ph_q == PH_W'(K_HALF + K_HALF / 2));
   // A write straight after a read would clash with returning data
   assign issue = mid_lo && head_valid && !(last_rd_q && (h_rw == DIR_WRITE));
   assign head_ready = issue;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ph_q <= PH_W'(2 * K_HALF - 1);
         k_q <= 1'b0;
         k_n_q <= 1'b1;
         c_q <= 1'b0;
         c_n_q <= 1'b1;
         single_q <= 1'b0;
      end else begin
         ph_q <= ph_next;
         k_q <= k_next;
         k_n_q <= !k_next;
         c_q <= SINGLE_CLK ? 1'b0 : k_next;
         c_n_q <= SINGLE_CLK ? 1'b0 : !k_next;
         single_q <= SINGLE_CLK;
      end
   end

   // Commands change mid-low, clear of the K rise
   // strobe with direction
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         define_n_q <= 1'b1;
         rw_q <= 1'b1;
         addr_q <= '0;
         cmd_rd_q <= 1'b0;
         last_rd_q <= 1'b0;
      end else if (mid_lo) begin
         define_n_q <= !issue;
         cmd_rd_q <= issue && (h_rw == DIR_READ);
         last_rd_q <= issue && (h_rw == DIR_READ);
         if (issue) begin
            rw_q <= h_rw;
            addr_q <= h_addr;
         end
      end
   end

   // Word one at the next K rise, word two at the K-bar rise after
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_stage_q <= 1'b0;
         wr_word1_q <= 1'b0;
         wd0_q <= '0;
         wd1_q <= '0;
         m0_q <= '1;
         m1_q <= '1;
         wd1_drv_q <= '0;
         m1_drv_q <= '1;
         dq_o_q <= '0;
         dq_oe_n_q <= 1'b1;
         mask_n_q <= '1;
      end else if (mid_lo) begin
         wr_stage_q <= issue && (h_rw == DIR_WRITE);
         wr_word1_q <= wr_stage_q;
         if (issue && (h_rw == DIR_WRITE)) begin
            wd0_q <= h_d0;
            wd1_q <= h_d1;
            m0_q <= h_m0;
            m1_q <= h_m1;
         end
         wd1_drv_q <= wd1_q;
         m1_drv_q <= m1_q;
         dq_o_q <= wd0_q;
         dq_oe_n_q <= !wr_stage_q;
         mask_n_q <= wr_stage_q ? m0_q : '1;
      end else if (mid_hi && wr_word1_q) begin
         dq_o_q <= wd1_drv_q;
         mask_n_q <= m1_drv_q;
      end
   end

   // Read capture on the echoes
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ret_s1_q <= '0;
         ret_s2_q <= '0;
         echo_prev_q <= 2'h0;
      end else begin
         ret_s1_q <= {LINK.returned_timing_out, LINK.returned_timing_out_n, LINK.dq};
         ret_s2_q <= ret_s1_q;
         echo_prev_q <= ret_s2_q[DATA_W+1:DATA_W];
      end
   end

   assign echo_rise = ret_s2_q[DATA_W+1] && !echo_prev_q[1];
   assign echon_rise = ret_s2_q[DATA_W] && !echo_prev_q[0];

   // Data at echo rise n belongs to the read loaded at K rise n-1
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         hist_q <= 2'h0;
         cap_q <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_d0_q <= '0;
         rd_d1_q <= '0;
      end else begin
         rd_valid_q <= 1'b0;
         if (at_rise) begin
            hist_q <= {hist_q[0], cmd_rd_q};
         end
         if (echo_rise) begin
            cap_q <= hist_q[1];
            if (hist_q[1]) begin
               rd_d0_q <= ret_s2_q[DATA_W-1:0];
            end
         end
         if (echon_rise && cap_q) begin
            rd_d1_q <= ret_s2_q[DATA_W-1:0];
            rd_valid_q <= 1'b1;
            cap_q <= 1'b0;
         end
      end
   end

   assign LINK.k = k_q;
   assign LINK.k_n = k_n_q;
   assign LINK.c = c_q;
   assign LINK.c_n = c_n_q;
   assign LINK.single_clk = single_q;
   assign LINK.cycle_define_n = define_n_q;
   assign LINK.rw = rw_q;
   assign LINK.addr = addr_q;
   assign LINK.lane_write_mask_n = mask_n_q;
   assign LINK.dq_h_o = dq_o_q;
   assign LINK.dq_h_oe_n = dq_oe_n_q;
   assign RD_VALID = rd_valid_q;
   assign RD_DATA0 = rd_d0_q;
   assign RD_DATA1 = rd_d1_q;
endmodule : dsp_host

// ===== rtl/dsp_defs.svh
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
`define DSP_DATA_W 36
`define DSP_ADDR_W 22
`define DSP_LANE_W 9
`define DSP_BURST_LEN 2
`define DSP_FIFO_DEPTH 8
`define DSP_CLK_PERIOD_NS 50
`define DSP_K_PERIOD_NS 400
`define DSP_K_HALF_CYC (`DSP_K_PERIOD_NS / (2 * `DSP_CLK_PERIOD_NS))
`endif

// ===== rtl/dsp_pkg.sv
package dsp_pkg;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WORD0 = 2'b01,
      RD_WORD1 = 2'b10
   } dsp_rd_phase_t;
   typedef enum logic {
      DIR_WRITE = 1'b0,
      DIR_READ = 1'b1
   } dsp_dir_t;
endpackage : dsp_pkg

// ===== rtl/dsp_link_if.sv
`timescale 1ns/1ps
`include "dsp_defs.svh"
interface dsp_link_if #(
   parameter int ADDR_W = `DSP_ADDR_W,
   parameter int DATA_W = `DSP_DATA_W
);
   localparam int LANES = DATA_W / `DSP_LANE_W;
   logic k;
   logic k_n;
   logic c;
   logic c_n;
   logic single_clk;
   logic cycle_define_n;
   logic rw;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0] lane_write_mask_n;
   logic [DATA_W-1:0] dq_h_o;
   logic dq_h_oe_n;
   logic [DATA_W-1:0] dq_d_o;
   logic dq_d_oe_n;
   logic [DATA_W-1:0] dq;
   logic returned_timing_out;
   logic returned_timing_out_n;
   // Released wire reads low, so stale data never lingers; clashes are left to the checker
   assign dq = ({DATA_W{!dq_d_oe_n}} & dq_d_o) | ({DATA_W{!dq_h_oe_n}} & dq_h_o);
   modport device (
      input k, k_n, c, c_n, single_clk, cycle_define_n, rw, addr, lane_write_mask_n, dq,
      output dq_d_o, dq_d_oe_n, returned_timing_out, returned_timing_out_n
   );
   modport host (
      output k, k_n, c, c_n, single_clk, cycle_define_n, rw, addr, lane_write_mask_n,
      output dq_h_o, dq_h_oe_n,
      input dq, returned_timing_out, returned_timing_out_n
   );
endinterface : dsp_link_if

// ===== rtl/dsp_fifo.sv
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `DSP_FIFO_DEPTH
) (
   // Fill side
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [WIDTH-1:0] IN_DATA,
   // Drain side
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [WIDTH-1:0] OUT_DATA,
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] count_q;
   logic [PW:0] count_d;
   logic ready_q;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_next

   assign push = IN_VALID && ready_q;
   assign pop = OUT_VALID && OUT_READY;
   assign IN_READY = ready_q;
   assign OUT_VALID = (count_q != '0);
   assign OUT_DATA = mem_q[rd_ptr_q];

   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (push) begin
         mem_q[wr_ptr_q] <= IN_DATA;
      end
   end

   // Ready is registered so a full buffer stalls the filler at once
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         ready_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= ptr_next(wr_ptr_q);
         end
         if (pop) begin
            rd_ptr_q <= ptr_next(rd_ptr_q);
         end
         count_q <= count_d;
         ready_q <= (count_d < (PW + 1)'(DEPTH));
      end
   end
endmodule : dsp_fifo

// ===== rtl/dsp_device.sv
`timescale 1ns/1ps
`include "dsp_defs.svh"
// Behaviour
// - Write words taken on K and K-bar rises
// - Read words driven on output clock rises
// - Single clock mode launches from K pair
// - Data pins released when no read active
// - Controller lowers define strobe with new access
// - Every access moves exactly two words
// - Lane masks active low, sampled both edges
// - Each mask covers one nine-bit lane
// - Mask sampled with its own data word
// - Masked lane leaves stored byte unchanged
// - One address bus serves both directions
// - Seed bit loads burst counter, advances linearly
// - Controller supplies 22 or 23 address bits
// - Storage split into two internal arrays
// - Address ignored while not selected
// - Direction high reads, low writes
// - Accesses start only at K rise
// - Free-running echo clocks follow output clocks
// - Single clock mode echoes follow K pair
module dsp_device #(
   parameter int ADDR_W = `DSP_ADDR_W,
   parameter int DATA_W = `DSP_DATA_W
) (
   // Memory link
   dsp_link_if.device LINK,
   // Status
   output logic RD_ACTIVE,
   output logic WR_ACTIVE,
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N
);
   import dsp_pkg::*;

   localparam int LANE_W = `DSP_LANE_W;
   localparam int LANES = DATA_W / LANE_W;
   localparam int ROW_W = ADDR_W - 1;
   localparam int ROWS = 2 ** ROW_W;
   localparam int IN_W = 7 + ADDR_W + LANES + DATA_W;

   function automatic logic [DATA_W-1:0] merge_lanes(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [LANES-1:0] keep_n
   );
      logic [DATA_W-1:0] res;
      res = old_word;
      for (int i = 0; i < LANES; i++) begin
         if (!keep_n[i]) begin
            res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction : merge_lanes

   // Pin synchronisers
   logic [IN_W-1:0] pin_raw;
   logic [IN_W-1:0] pin_s1_q;
   logic [IN_W-1:0] pin_s2_q;
   logic k_s;
   logic kn_s;
   logic c_s;
   logic cn_s;
   logic single_s;
   logic define_n_s;
   logic rw_s;
   logic [ADDR_W-1:0] addr_s;
   logic [LANES-1:0] mask_n_s;
   logic [DATA_W-1:0] dq_s;

   // Edge finding
   logic [3:0] clk_prev_q;
   logic k_rise;
   logic kn_rise;
   logic c_rise;
   logic cn_rise;
   logic out_rise;
   logic outn_rise;

   // Two arrays, even and odd word address
   logic [DATA_W-1:0] mem_q [2][ROWS];

   // Command stages
   logic new_access;
   logic new_read;
   logic new_write;
   logic rd_pend_q;
   logic [ROW_W-1:0] rd_row_q;
   logic rd_seed_q;
   logic wr_pend_q;
   logic [ROW_W-1:0] wr_row_q;
   logic wr_seed_q;
   logic wr_act_q;
   logic [ROW_W-1:0] wr_row1_q;
   logic wr_bank_q;

   // Read launch
   dsp_rd_phase_t rd_phase_q;
   logic rd_bank_q;
   logic rd_bank_next;
   logic [ROW_W-1:0] rd_cur_row_q;
   logic [DATA_W-1:0] dq_o_q;
   logic dq_oe_n_q;
   logic echo_q;
   logic echo_n_q;
   logic rd_busy_q;
   logic wr_busy_q;

   assign pin_raw = {LINK.k, LINK.k_n, LINK.c, LINK.c_n, LINK.single_clk,
                     LINK.cycle_define_n, LINK.rw, LINK.addr,
                     LINK.lane_write_mask_n, LINK.dq};

   // Second stage alone feeds the logic
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   assign {k_s, kn_s, c_s, cn_s, single_s, define_n_s, rw_s,
           addr_s, mask_n_s, dq_s} = pin_s2_q;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         clk_prev_q <= 4'h0;
      end else begin
         clk_prev_q <= {k_s, kn_s, c_s, cn_s};
      end
   end

   assign k_rise = k_s && !clk_prev_q[3];
   assign kn_rise = kn_s && !clk_prev_q[2];
   assign c_rise = c_s && !clk_prev_q[1];
   assign cn_rise = cn_s && !clk_prev_q[0];
   assign out_rise = single_s ? k_rise : c_rise;
   assign outn_rise = single_s ? kn_rise : cn_rise;

   assign new_access = k_rise && !define_n_s;
   assign new_read = new_access && (rw_s == DIR_READ);
   assign new_write = new_access && (rw_s == DIR_WRITE);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rd_pend_q <= 1'b0;
         rd_row_q <= '0;
         rd_seed_q <= 1'b0;
      end else if (k_rise) begin
         rd_pend_q <= new_read;
         if (new_read) begin
            rd_row_q <= addr_s[ADDR_W-1:1];
            rd_seed_q <= addr_s[0];
         end
      end else if (out_rise) begin
         rd_pend_q <= 1'b0;
      end
   end

   // Write data trails its command by one K period
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend_q <= 1'b0;
         wr_row_q <= '0;
         wr_seed_q <= 1'b0;
         wr_act_q <= 1'b0;
         wr_row1_q <= '0;
         wr_bank_q <= 1'b0;
      end else if (k_rise) begin
         wr_pend_q <= new_write;
         if (new_write) begin
            wr_row_q <= addr_s[ADDR_W-1:1];
            wr_seed_q <= addr_s[0];
         end
         wr_act_q <= wr_pend_q;
         if (wr_pend_q) begin
            wr_bank_q <= wr_seed_q + 1'b1;
            wr_row1_q <= wr_row_q;
         end
      end else if (kn_rise) begin
         wr_act_q <= 1'b0;
      end
   end

   // word one at K, word two at K-bar
   always_ff @(posedge CLOCK) begin
      if (k_rise && wr_pend_q) begin
         mem_q[wr_seed_q][wr_row_q] <=
            merge_lanes(mem_q[wr_seed_q][wr_row_q], dq_s, mask_n_s);
      end
      if (kn_rise && wr_act_q) begin
         mem_q[wr_bank_q][wr_row1_q] <=
            merge_lanes(mem_q[wr_bank_q][wr_row1_q], dq_s, mask_n_s);
      end
   end

   assign rd_bank_next = rd_bank_q + 1'b1;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rd_phase_q <= RD_IDLE;
         rd_bank_q <= 1'b0;
         rd_cur_row_q <= '0;
         dq_o_q <= '0;
         dq_oe_n_q <= 1'b1;
      end else begin
         unique case (rd_phase_q)
            RD_IDLE, RD_WORD1: begin
               if (out_rise) begin
                  if (rd_pend_q) begin
                     rd_phase_q <= RD_WORD0;
                     rd_bank_q <= rd_seed_q;
                     rd_cur_row_q <= rd_row_q;
                     dq_o_q <= mem_q[rd_seed_q][rd_row_q];
                     dq_oe_n_q <= 1'b0;
                  end else begin
                     rd_phase_q <= RD_IDLE;
                     dq_oe_n_q <= 1'b1;
                  end
               end
            end
            RD_WORD0: begin
               if (outn_rise) begin
                  rd_phase_q <= RD_WORD1;
                  rd_bank_q <= rd_bank_next;
                  dq_o_q <= mem_q[rd_bank_next][rd_cur_row_q];
               end
            end
            default: begin
               rd_phase_q <= RD_IDLE;
               dq_oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // Echoes share the data's register stage so they stay aligned
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         echo_q <= 1'b0;
         echo_n_q <= 1'b0;
      end else begin
         echo_q <= single_s ? k_s : c_s;
         echo_n_q <= single_s ? kn_s : cn_s;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rd_busy_q <= 1'b0;
         wr_busy_q <= 1'b0;
      end else begin
         rd_busy_q <= rd_pend_q || (rd_phase_q != RD_IDLE);
         wr_busy_q <= wr_pend_q || wr_act_q;
      end
   end

   assign LINK.dq_d_o = dq_o_q;
   assign LINK.dq_d_oe_n = dq_oe_n_q;
   assign LINK.returned_timing_out = echo_q;
   assign LINK.returned_timing_out_n = echo_n_q;
   assign RD_ACTIVE = rd_busy_q;
   assign WR_ACTIVE = wr_busy_q;
endmodule : dsp_device

// ===== verification/dsp_link_asserts.sv
`timescale 1ns/1ps
module dsp_link_asserts #(
   parameter int K_HALF = 4
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Host driven link signals
   input wire logic k,
   input wire logic c,
   input wire logic single_clk,
   input wire logic cycle_define_n,
   input wire logic rw,
   input wire logic dq_h_oe_n,
   // Device driven link signals
   input wire logic dq_d_oe_n,
   input wire logic returned_timing_out
);
   logic [15:0] rd_hist_q;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   // Read commands seen at the pins, one bit per cycle; back to back reads stay distinct
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rd_hist_q <= 16'h0000;
      end else begin
         rd_hist_q <= {rd_hist_q[14:0], ($rose(k) && !cycle_define_n && rw)};
      end
   end
   a_bus_no_clash: assert property (dq_d_oe_n || dq_h_oe_n)
      else $error("both ends drive the data wire");
   a_strobe_one_period: assert property ($fell(cycle_define_n) |-> !cycle_define_n [*8])
      else $error("access strobe shorter than one input clock period");
   a_k_rise_period: assert property ($rose(k) |-> k [*4] ##1 !k [*4] ##1 k)
      else $error("input clock period wrong");
   a_out_clock_src: assert property (single_clk == $past(single_clk, 2)
         |-> c == (k && !single_clk))
      else $error("output clock pair not following mode");
   a_echo_dual_mode: assert property ($rose(c) |-> ##[1:5] returned_timing_out)
      else $error("echo clock not following output clock");
   a_echo_single_mode: assert property ($rose(k) && single_clk && $past(single_clk, 8)
         |-> ##[1:5] returned_timing_out)
      else $error("echo clock not following input clock in single mode");
   a_read_launch: assert property ($rose(k) && !cycle_define_n && rw
         |-> ##[9:13] !dq_d_oe_n)
      else $error("read data not driven one period after command");
   a_write_no_drive: assert property ($rose(k) && !cycle_define_n && !rw
         |-> ##9 dq_d_oe_n [*5])
      else $error("device drives data during a write");
   a_read_two_words: assert property ($fell(dq_d_oe_n) |-> !dq_d_oe_n [*8])
      else $error("read drive shorter than two words");
   a_drive_needs_read: assert property ($fell(dq_d_oe_n)
         |-> (rd_hist_q[12:8] != 5'h00))
      else $error("device drives data without a read command");
endmodule : dsp_link_asserts

// ===== verification/ddr_two_word_burst_sram_port_tb.sv
`timescale 1ns/1ps
`include "dsp_defs.svh"
module ddr_two_word_burst_sram_port_tb;
   import dsp_pkg::*;
   // Small array keeps the flop memory cheap
   localparam int AW = 6;
   localparam int DW = 36;
   localparam int LN = DW / `DSP_LANE_W;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   dsp_dir_t req_rw = DIR_WRITE;
   logic [AW-1:0] req_addr = '0;
   logic [DW-1:0] req_w0 = '0;
   logic [DW-1:0] req_w1 = '0;
   logic [LN-1:0] req_m0_n = '1;
   logic [LN-1:0] req_m1_n = '1;
   logic single_clk = 1'b0;
   logic rd_valid;
   logic [DW-1:0] rd_d0;
   logic [DW-1:0] rd_d1;
   logic rd_active;
   logic wr_active;
   logic full_seen = 1'b0;
   logic [DW-1:0] mem_m [0:(1<<AW)-1];
   logic [2*DW-1:0] exp_q [$];
   int err_count = 0;
   int samples_checked = 0;
   int seed = 32'h2a61;
   int cycles = 0;
   initial begin
      forever #25 clock = ~clock;
   end
   dsp_link_if #(.ADDR_W(AW), .DATA_W(DW)) link ();
   dsp_device #(.ADDR_W(AW), .DATA_W(DW)) i_dsp_device (.LINK(link),
      .RD_ACTIVE(rd_active), .WR_ACTIVE(wr_active), .CLOCK(clock), .RST_N(rst_n));
   dsp_host #(.ADDR_W(AW), .DATA_W(DW)) i_dsp_host (.LINK(link),
      .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_RW(req_rw), .REQ_ADDR(req_addr),
      .REQ_WDATA0(req_w0), .REQ_WDATA1(req_w1), .REQ_MASK0_N(req_m0_n),
      .REQ_MASK1_N(req_m1_n), .SINGLE_CLK(single_clk), .RD_VALID(rd_valid),
      .RD_DATA0(rd_d0), .RD_DATA1(rd_d1), .CLOCK(clock), .RST_N(rst_n));
   dsp_link_asserts #(.K_HALF(`DSP_K_HALF_CYC)) i_dsp_link_asserts (.CLOCK(clock),
      .RST_N(rst_n), .k(link.k), .c(link.c), .single_clk(link.single_clk),
      .cycle_define_n(link.cycle_define_n), .rw(link.rw), .dq_h_oe_n(link.dq_h_oe_n),
      .dq_d_oe_n(link.dq_d_oe_n), .returned_timing_out(link.returned_timing_out));
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [2*DW-1:0] exp,
                        input logic [2*DW-1:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   function automatic logic [DW-1:0] rnd();
      return DW'({$random(seed), $random(seed)});
   endfunction : rnd
   // Lanes with a low mask take the new data, others keep the old
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
      input logic [DW-1:0] new_w, input logic [LN-1:0] m_n);
      logic [DW-1:0] r;
      r = old_w;
      for (int l = 0; l < LN; l++) begin
         if (!m_n[l]) begin
            r[l*`DSP_LANE_W +: `DSP_LANE_W] = new_w[l*`DSP_LANE_W +: `DSP_LANE_W];
         end
      end
      return r;
   endfunction : merge
   // Offers one request and returns once it is taken
   task automatic send(input dsp_dir_t rw, input int a, input logic [DW-1:0] w0,
      input logic [DW-1:0] w1, input logic [LN-1:0] m0_n, input logic [LN-1:0] m1_n);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_rw = rw;
      req_addr = AW'(a);
      req_w0 = w0;
      req_w1 = w1;
      req_m0_n = m0_n;
      req_m1_n = m1_n;
      while (req_ready !== 1'b1 && n < 400) begin
         full_seen = 1'b1;
         n++;
         @(posedge clock);
         #1;
      end
      if (n >= 400) begin
         err_count++;
      end
      @(posedge clock);
      #1;
      // second word goes to the paired location
      if (rw == DIR_READ) begin
         exp_q.push_back({mem_m[a], mem_m[a ^ 1]});
      end else begin
         mem_m[a] = merge(mem_m[a], w0, m0_n);
         mem_m[a ^ 1] = merge(mem_m[a ^ 1], w1, m1_n);
      end
   endtask : send
   // Idle until every read has come back and the queue has emptied
   task automatic drain();
      int n;
      n = 0;
      req_valid = 1'b0;
      while ((exp_q.size() != 0 || n < 200) && n < 3000) begin
         @(posedge clock);
         n++;
      end
      #1;
   endtask : drain
   // Read results are looked at mid-cycle where the pulse is settled
   always @(negedge clock) begin
      cycles++;
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected read", '0, {rd_d0, rd_d1});
         end else begin
            check("read burst", exp_q.pop_front(), {rd_d0, rd_d1});
         end
      end
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin : main
      repeat (5) @(posedge clock);
      #1;
      rst_n = 1'b1;
      @(posedge clock);
      #1;
      // Back to back writes of every row fill the request buffer
      for (int r = 0; r < 32; r++) begin
         send(DIR_WRITE, 2*r + ($random(seed) & 1), rnd(), rnd(), '0, '0);
      end
      check("buffer refusal", 1, full_seen);
      // Random lane masks, each with its own word
      for (int r = 0; r < 16; r++) begin
         send(DIR_WRITE, 2*r + ($random(seed) & 1), rnd(), rnd(),
              LN'($random(seed)), LN'($random(seed)));
      end
      drain();
      for (int r = 0; r < 32; r++) begin
         send(DIR_READ, 2*r + ($random(seed) & 1), '0, '0, '1, '1);
      end
      drain();
      single_clk = 1'b1;
      drain();
      // Reads interleaved with writes to other rows, turnaround each time
      for (int r = 0; r < 16; r++) begin
         send(DIR_READ, 2*r + ($random(seed) & 1), '0, '0, '1, '1);
         send(DIR_WRITE, 2*r + 32 + ($random(seed) & 1), rnd(), rnd(), '0,
              LN'($random(seed)));
      end
      drain();
      for (int r = 16; r < 32; r++) begin
         send(DIR_READ, 2*r + ($random(seed) & 1), '0, '0, '1, '1);
      end
      drain();
      check("reads outstanding", 0, exp_q.size());
      check("status idle", 0, {rd_active, wr_active});
      tally_and_finish();
   end
endmodule : ddr_two_word_burst_sram_port_tb
